// File: logic/sac_pkg.sv
// Constants, register map and carrier types for the SAR converter control block.
// Assumes a single 10 MHz clock and a synchronous active-low reset.
//
// Summary of operation
// - Result is placed left or right justified per the justify select bit.
// - Converter runs only while converter_on, control bit 0, is one.
// - Writing go bit 1 with the converter already on starts a conversion; reads one while converting.
// - On completion go clears, done flag sets, both result bytes load.
// - Clearing go early aborts; result bytes keep the previous result.
// - After an abort wait two TAD, then acquisition restarts automatically.
// - Reset returns all registers to reset values; converter off, conversion ended.
// - Halt conversion needs the RC clock; RC start waits one instruction cycle.
// - In halt with RC clock and irq enable, completion wakes the device.
// - In halt with RC clock and no irq enable, converter powers down after.
// - Halt entry with a non-RC clock aborts and powers down; on bit stays.
// - Channel select bits 4-2 route input 0 to input 7.
// - Clock select bits 6-4 pick divide 2..64 or the RC clock.
// - Unimplemented bits read as zero.
// - Left: high byte bits 9-2, low byte top bits 1-0; right: high low bits 9-8.
// - A conversion takes 11 TAD, one bit per TAD from the MSB.
// - Done flag sets at every completion regardless of irq enable.
// - Reference select one picks the external pin, zero the supply.
package sac_pkg;

  // Register indices on the 3-bit address port
  localparam logic [2:0] OFS_CTRL   = 3'h0;
  localparam logic [2:0] OFS_CLKSEL = 3'h1;
  localparam logic [2:0] OFS_RESHI  = 3'h2;
  localparam logic [2:0] OFS_RESLO  = 3'h3;
  localparam logic [2:0] OFS_STAT   = 3'h4;

  // Conversion control fields
  localparam int CTRL_ON_BIT   = 0;
  localparam int CTRL_GO_BIT   = 1;
  localparam int CTRL_CHAN_LSB = 2;
  localparam int CTRL_REF_BIT  = 6;
  localparam int CTRL_JUST_BIT = 7;
  // Clock select field and status fields
  localparam int CS_LSB        = 4;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_IE_BIT   = 1;

  // Reset values
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [2:0] RST_CLKSEL = 3'h0;
  localparam logic [7:0] RST_RES    = 8'h00;

  // RC clock code pattern x11 in the low two bits of clock select
  localparam logic [1:0] CS_RC_LOW = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int INSTR_NS      = 400;
  localparam int INSTR_CYC     = (INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TADS     = 11;
  localparam int ABORT_TADS    = 2;
  localparam int RES_BITS      = 10;

  // Register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sac_bus_req_type;

  // Controls toward the analog front end
  typedef struct packed {
    logic [2:0] chanSel;
    logic       refExt;
    logic [9:0] dacCode;
    logic       sampleOn;
    logic       powerOn;
  } sac_ana_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CONV,
    ST_ABWAIT
  } sac_state_type;

endpackage

// File: logic/sac_tad_gen.sv
// Bit-period (TAD) tick generator for the conversion sequencer.
// Assumes rcTick is a one-cycle pulse synchronous to clk from the RC oscillator.
module sac_tad_gen
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] clkSel,
  input  wire logic       rcTick,
  // Tick out
  output logic            tadTick
);

  logic [5:0] divCnt_ff;
  logic [5:0] nxt_divCnt;
  logic [2:0] divShift;
  logic [6:0] divPeriod;
  logic [5:0] divLast;
  logic       rcSel;

  // Code to shift: 000,100,001,101,010,110 give 2..64
  assign rcSel     = (clkSel[1:0] == CS_RC_LOW);
  assign divShift  = {clkSel[1:0], clkSel[2]};
  assign divPeriod = 7'h02 << divShift;
  assign divLast   = 6'(divPeriod - 7'h01);
  // RC ticks pass straight through so halt conversions keep running
  assign tadTick   = run & (rcSel ? rcTick : (divCnt_ff == divLast));
  // Counter restarts with each run so the first TAD is whole
  assign nxt_divCnt = (!run || tadTick || rcSel) ? 6'h00 : 6'(divCnt_ff + 6'h01);

  // Divider count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt_ff <= 6'h00;
    end else begin
      divCnt_ff <= nxt_divCnt;
    end
  end

endmodule

// File: logic/sac_ctrl.sv
// Control logic of a 10-bit successive-approximation converter: registers,
// sequencer, abort and halt handling, result justification.
// Assumes the comparator output is valid one TAD after dacCode changes and
// that sleepReq and rcTick are synchronous to clk.
module sac_ctrl
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Register port
  input  wire sac_bus_req_type busReq,
  output logic [7:0]           rdData,
  // Analog front end
  input  wire logic            compIn,
  output sac_ana_type          anaOut,
  // System
  input  wire logic            sleepReq,
  input  wire logic            rcTick,
  output logic                 wakeReq
);

  // Registers
  logic          convOn_ff, goFlag_ff, refExt_ff, just_ff;
  logic [2:0]    chan_ff, clkSel_ff;
  logic          doneFlag_ff, irqEn_ff;
  logic [7:0]    resHi_ff, resLo_ff, rdData_ff;
  sac_state_type state_ff, nxt_state;
  logic [9:0]    sar_ff, trial_ff;
  logic [2:0]    dlyCnt_ff;
  logic          abTad_ff, sleepPrev_ff, pwrDown_ff, wakeReq_ff;
  logic [3:0]    tadHelp_ff;

  // Next values
  logic          nxt_goFlag, nxt_doneFlag, nxt_pwrDown, nxt_wake;
  logic [7:0]    nxt_resHi, nxt_resLo, nxt_rdData;
  logic [9:0]    nxt_sar, nxt_trial;

  // Decodes
  logic          wrCtrl, wrClk, wrHi, wrLo, wrStat;
  logic          rcSel, sleepRise, active, startReq, swAbort, haltAbort;
  logic          tadTick, run, lastBit, complete;
  logic [9:0]    newSar;
  logic [7:0]    packHi, packLo, ctrlRd, clkRd, statRd;

  // Register write decode
  assign wrCtrl = busReq.wr && (busReq.addr == OFS_CTRL);
  assign wrClk  = busReq.wr && (busReq.addr == OFS_CLKSEL);
  assign wrHi   = busReq.wr && (busReq.addr == OFS_RESHI);
  assign wrLo   = busReq.wr && (busReq.addr == OFS_RESLO);
  assign wrStat = busReq.wr && (busReq.addr == OFS_STAT);

  // Sequencer events
  assign rcSel     = (clkSel_ff[1:0] == CS_RC_LOW);
  assign sleepRise = sleepReq & ~sleepPrev_ff;
  assign active    = (state_ff == ST_DELAY) || (state_ff == ST_CONV);
  // Go counts only once the converter is already on; halt power-down ignores it
  assign startReq  = wrCtrl & busReq.wdata[CTRL_GO_BIT] & busReq.wdata[CTRL_ON_BIT]
                   & (state_ff == ST_IDLE) & ~pwrDown_ff & convOn_ff;
  assign swAbort   = wrCtrl & ~busReq.wdata[CTRL_GO_BIT] & active;
  assign haltAbort = sleepRise & ~rcSel & active;
  // Abort drops run for one cycle so the abort wait starts on a whole TAD
  assign run       = ((state_ff == ST_CONV) && !swAbort) || (state_ff == ST_ABWAIT);
  assign lastBit   = (state_ff == ST_CONV) & tadTick & trial_ff[0];
  // Any abort in the final TAD wins, so no partial result escapes
  assign complete  = lastBit & ~swAbort & ~haltAbort & convOn_ff;
  assign newSar    = sar_ff | (compIn ? trial_ff : 10'h000);

  // Justified packing of the finished result
  assign packHi = just_ff ? {6'h00, newSar[9:8]} : newSar[9:2];
  assign packLo = just_ff ? newSar[7:0] : {newSar[1:0], 6'h00};

  // Read-back images; bit 5 and unused clock bits read zero
  assign ctrlRd = {just_ff, refExt_ff, 1'b0, chan_ff, goFlag_ff, convOn_ff};
  assign clkRd  = {1'b0, clkSel_ff, 4'h0};
  assign statRd = {6'h00, irqEn_ff, doneFlag_ff};

  sac_tad_gen u_tad (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (run),
    .clkSel  (clkSel_ff),
    .rcTick  (rcTick),
    .tadTick (tadTick)
  );

  // Sequencer state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (startReq) begin
          nxt_state = rcSel ? ST_DELAY : ST_CONV;
        end
      end
      ST_DELAY: begin
        if (swAbort) begin
          nxt_state = ST_ABWAIT;
        end else if (haltAbort) begin
          nxt_state = ST_IDLE;
        end else if (dlyCnt_ff == 3'(INSTR_CYC - 1)) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (swAbort) begin
          nxt_state = ST_ABWAIT;
        end else if (haltAbort || complete) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ABWAIT: begin
        if (tadTick && abTad_ff) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
    // Turning the converter off ends any activity
    if (!convOn_ff) begin
      nxt_state = ST_IDLE;
    end
  end

  // Go flag: written by software, cleared by hardware at the end
  always_comb begin
    nxt_goFlag = goFlag_ff;
    if (wrCtrl) begin
      nxt_goFlag = busReq.wdata[CTRL_GO_BIT] & busReq.wdata[CTRL_ON_BIT]
                 & (active | startReq);
    end
    if (complete || haltAbort || !convOn_ff) begin
      nxt_goFlag = 1'b0;
    end
  end

  // Successive approximation: first TAD samples, then one bit per TAD
  always_comb begin
    nxt_sar   = sar_ff;
    nxt_trial = trial_ff;
    if (startReq) begin
      nxt_sar   = 10'h000;
      nxt_trial = 10'h000;
    end else if ((state_ff == ST_CONV) && tadTick) begin
      if (trial_ff == 10'h000) begin
        nxt_trial = 10'h200;
      end else begin
        nxt_sar   = newSar;
        nxt_trial = trial_ff >> 1;
      end
    end
  end

  // Result bytes: completion loads, otherwise software may write
  assign nxt_resHi = complete ? packHi : (wrHi ? busReq.wdata : resHi_ff);
  assign nxt_resLo = complete ? packLo : (wrLo ? busReq.wdata : resLo_ff);

  // Done flag: set beats a same-cycle clear
  assign nxt_doneFlag = complete | (wrStat ? busReq.wdata[STAT_DONE_BIT] : doneFlag_ff);

  // Halt power-down; released when halt ends
  always_comb begin
    nxt_pwrDown = pwrDown_ff;
    if (sleepRise && !rcSel) begin
      nxt_pwrDown = 1'b1;
    end
    if (complete && sleepReq && rcSel && !irqEn_ff) begin
      nxt_pwrDown = 1'b1;
    end
    if (!sleepReq) begin
      nxt_pwrDown = 1'b0;
    end
  end

  assign nxt_wake = complete & sleepReq & rcSel & irqEn_ff;

  // Read mux; unmapped indices read zero
  assign nxt_rdData = !busReq.rd                 ? 8'h00 :
                      (busReq.addr == OFS_CTRL)   ? ctrlRd :
                      (busReq.addr == OFS_CLKSEL) ? clkRd :
                      (busReq.addr == OFS_RESHI)  ? resHi_ff :
                      (busReq.addr == OFS_RESLO)  ? resLo_ff :
                      (busReq.addr == OFS_STAT)   ? statRd : 8'h00;

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {just_ff, refExt_ff} <= RST_CTRL[7:6];
      chan_ff              <= RST_CTRL[4:2];
      convOn_ff            <= RST_CTRL[CTRL_ON_BIT];
      clkSel_ff            <= RST_CLKSEL;
      irqEn_ff             <= 1'b0;
    end else begin
      if (wrCtrl) begin
        just_ff   <= busReq.wdata[CTRL_JUST_BIT];
        refExt_ff <= busReq.wdata[CTRL_REF_BIT];
        chan_ff   <= busReq.wdata[CTRL_CHAN_LSB +: 3];
        convOn_ff <= busReq.wdata[CTRL_ON_BIT];
      end
      if (wrClk) begin
        clkSel_ff <= busReq.wdata[CS_LSB +: 3];
      end
      if (wrStat) begin
        irqEn_ff <= busReq.wdata[STAT_IE_BIT];
      end
    end
  end

  // Sequencer and result registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      goFlag_ff   <= 1'b0;
      sar_ff      <= 10'h000;
      trial_ff    <= 10'h000;
      resHi_ff    <= RST_RES;
      resLo_ff    <= RST_RES;
      doneFlag_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      goFlag_ff   <= nxt_goFlag;
      sar_ff      <= nxt_sar;
      trial_ff    <= nxt_trial;
      resHi_ff    <= nxt_resHi;
      resLo_ff    <= nxt_resLo;
      doneFlag_ff <= nxt_doneFlag;
    end
  end

  // Delay counters, halt tracking, outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dlyCnt_ff    <= 3'h0;
      abTad_ff     <= 1'b0;
      sleepPrev_ff <= 1'b0;
      pwrDown_ff   <= 1'b0;
      wakeReq_ff   <= 1'b0;
      rdData_ff    <= 8'h00;
    end else begin
      dlyCnt_ff    <= (state_ff == ST_DELAY) ? 3'(dlyCnt_ff + 3'h1) : 3'h0;
      abTad_ff     <= (state_ff == ST_ABWAIT) ? (abTad_ff | tadTick) : 1'b0;
      sleepPrev_ff <= sleepReq;
      pwrDown_ff   <= nxt_pwrDown;
      wakeReq_ff   <= nxt_wake;
      rdData_ff    <= nxt_rdData;
    end
  end

  // Outputs; dacCode is an OR of two flops, glitch-free enough for the DAC latch
  assign rdData          = rdData_ff;
  assign wakeReq         = wakeReq_ff;
  assign anaOut.chanSel  = chan_ff;
  assign anaOut.refExt   = refExt_ff;
  assign anaOut.dacCode  = sar_ff | trial_ff;
  assign anaOut.powerOn  = convOn_ff & ~pwrDown_ff;
  // Acquisition runs whenever powered and idle, so it restarts after aborts
  assign anaOut.sampleOn = convOn_ff & ~pwrDown_ff & (state_ff == ST_IDLE);

  // Helper: TAD ticks seen in the conversion state, for the length check
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tadHelp_ff <= 4'h0;
    end else if (state_ff != ST_CONV) begin
      tadHelp_ff <= 4'h0;
    end else if (tadTick) begin
      tadHelp_ff <= 4'(tadHelp_ff + 4'h1);
    end
  end

  a_done_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
    complete |=> doneFlag_ff && !goFlag_ff && (state_ff == ST_IDLE))
    else $error("completion did not set done and clear go");

  a_conv_eleven_tad: assert property (@(posedge clk) disable iff (!rst_n)
    complete |-> (tadHelp_ff == 4'hA))
    else $error("conversion did not last eleven TAD");

  a_abort_keeps_result: assert property (@(posedge clk) disable iff (!rst_n)
    (swAbort && !wrHi && !wrLo) |=> $stable(resHi_ff) && $stable(resLo_ff)
      && (state_ff == ST_ABWAIT))
    else $error("abort changed the result");

  a_abort_no_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (swAbort || haltAbort) && !wrStat |=> (doneFlag_ff == $past(doneFlag_ff)))
    else $error("aborted conversion set done flag");

  a_abort_wait_end: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ST_ABWAIT) && tadTick && abTad_ff && convOn_ff
      |=> (state_ff == ST_IDLE) ##0 anaOut.sampleOn == !pwrDown_ff)
    else $error("abort wait did not end after two TAD");

  a_rc_start_delay: assert property (@(posedge clk) disable iff (!rst_n)
    startReq && rcSel && !busReq.rd |=> (state_ff == ST_DELAY) && (dlyCnt_ff == 3'h0))
    else $error("RC start skipped the instruction delay");

  a_halt_abort: assert property (@(posedge clk) disable iff (!rst_n)
    haltAbort && !wrCtrl |=> (state_ff == ST_IDLE) && !goFlag_ff && pwrDown_ff && convOn_ff)
    else $error("halt entry did not abort and power down");

  a_halt_wake: assert property (@(posedge clk) disable iff (!rst_n)
    complete && sleepReq && rcSel && irqEn_ff |=> wakeReq)
    else $error("no wake on halt completion");

  a_left_justify: assert property (@(posedge clk) disable iff (!rst_n)
    complete && !just_ff |=> (resHi_ff == $past(newSar[9:2])) && (resLo_ff[5:0] == 6'h00))
    else $error("left justified result misplaced");

  a_off_idles: assert property (@(posedge clk) disable iff (!rst_n)
    !convOn_ff |=> (state_ff == ST_IDLE) && !goFlag_ff)
    else $error("converter ran while disabled");

endmodule

// File: sim/sac_ctrl_bench.sv
// Self-checking bench for the SAR converter control block.
// Assumes sac_pkg and sac_ctrl are compiled first; one 10 MHz clock.
module sac_ctrl_bench
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Design ports and bench state
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  sac_bus_req_type busReq = '0;
  logic [7:0]      rdData;
  logic            compIn = 1'b0;
  sac_ana_type     anaOut;
  logic            sleepReq = 1'b0;
  logic            rcTick = 1'b0;
  logic            wakeReq;
  logic [9:0]      target = 10'h000;
  logic [2:0]      rcCnt = 3'h0;
  logic [7:0]      rv;
  logic [15:0]     lastRes = 16'h0000;
  logic [2:0]      csTab [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  int              miscompares = 0;
  int              cmp_count = 0;
  int              cycles = 0;
  int              seed = 32'h74abf3b0;
  int              n;

  always #50 clk = ~clk;

  sac_ctrl u_dut (.clk(clk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
    .compIn(compIn), .anaOut(anaOut), .sleepReq(sleepReq), .rcTick(rcTick),
    .wakeReq(wakeReq));

  // Comparator model, slow RC ticks and the hang limit
  // Registered compare: dacCode settles a full TAD before it is sampled
  always @(posedge clk) begin
    compIn <= (anaOut.dacCode <= target);
    rcCnt  <= rcCnt + 3'h1;
    rcTick <= (rcCnt == 3'h0);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: bit %b, want %b", $time, got, exp);
    end
  endtask

  // Bus master: strobe one cycle, idle one cycle, so no double assignment
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq <= '0;
    #1;
    d = rdData;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk8(rv, exp);
  endtask

  task automatic waitCyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Expected {high, low} result bytes for either justification
  function automatic logic [15:0] fmt(input logic [9:0] r, input logic rj);
    fmt = rj ? {6'h00, r} : {r[9:2], r[1:0], 6'h00};
  endfunction

  // Full conversion; div of zero skips the duration check
  task automatic convert(input logic [2:0] cs, input logic rj, input int div,
                         input logic [9:0] tgt);
    logic [7:0] ctl;
    time        t0;
    int         el;
    ctl = {rj, 2'b00, tgt[2:0], 2'b01};
    target <= tgt;
    wr(OFS_CLKSEL, {1'b0, cs, 4'h0});
    wr(OFS_STAT, 8'h00);
    wr(OFS_CTRL, ctl);
    waitCyc(8);
    wr(OFS_CTRL, ctl | 8'h02);
    t0 = $time;
    do rd(OFS_CTRL, rv); while (rv[1] === 1'b1 && $time - t0 < 400000);
    el = int'(($time - t0) / 100);
    if (div > 0) chkBit(el >= 11 * div && el <= 11 * div + 4, 1'b1);
    chk8(rv, ctl);
    chk8({5'h00, anaOut.chanSel}, {5'h00, tgt[2:0]});
    rdc(OFS_STAT, 8'h01);
    lastRes = fmt(tgt, rj);
    rdc(OFS_RESHI, lastRes[15:8]);
    rdc(OFS_RESLO, lastRes[7:0]);
    wr(OFS_STAT, 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc(OFS_CTRL, 8'h00);
    rdc(OFS_CLKSEL, 8'h00);
    rdc(OFS_STAT, 8'h00);
    rdc(3'h5, 8'h00);
    waitCyc(1);
    chk8(rdData, 8'h00);
    $display("test reset values done");
    // Unimplemented bits and field routing
    wr(OFS_CTRL, 8'hfc);
    rdc(OFS_CTRL, 8'hdc);
    chkBit(anaOut.refExt, 1'b1);
    chkBit(anaOut.powerOn, 1'b0);
    wr(OFS_CLKSEL, 8'hff);
    rdc(OFS_CLKSEL, 8'h70);
    wr(3'h7, 8'hff);
    rdc(3'h7, 8'h00);
    for (n = 0; n < 8; n++) begin
      wr(OFS_CTRL, {3'h0, 3'(n), 2'b01});
      waitCyc(1);
      chk8({5'h00, anaOut.chanSel}, 8'(n));
      chkBit(anaOut.refExt, 1'b0);
      chkBit(anaOut.powerOn, 1'b1);
    end
    $display("test register fields done");
    // Every divider, extreme codes first, then random codes
    for (n = 0; n < 6; n++) begin
      convert(csTab[n], n[0], 2 << n, (n == 0) ? 10'h3ff : (n == 1) ? 10'h000
              : 10'($random(seed)));
    end
    $display("test conversions done");
    // Software abort at divide by 64
    wr(OFS_CTRL, 8'h03);
    waitCyc(200);
    wr(OFS_CTRL, 8'h01);
    waitCyc(60);
    chkBit(anaOut.sampleOn, 1'b0);
    waitCyc(67);
    chkBit(anaOut.sampleOn, 1'b0);
    waitCyc(2);
    chkBit(anaOut.sampleOn, 1'b1);
    rdc(OFS_STAT, 8'h00);
    rdc(OFS_RESHI, lastRes[15:8]);
    rdc(OFS_RESLO, lastRes[7:0]);
    $display("test abort done");
    // Halt entry with a divided clock aborts and powers down
    wr(OFS_CLKSEL, 8'h10);
    wr(OFS_CTRL, 8'h03);
    waitCyc(30);
    @(posedge clk) sleepReq <= 1'b1;
    waitCyc(2);
    chkBit(anaOut.powerOn, 1'b0);
    rdc(OFS_CTRL, 8'h01);
    rdc(OFS_STAT, 8'h00);
    rdc(OFS_RESLO, lastRes[7:0]);
    @(posedge clk) sleepReq <= 1'b0;
    waitCyc(2);
    chkBit(anaOut.powerOn, 1'b1);
    $display("test halt abort done");
    // Halt with RC clock and completion enable wakes the device
    target <= 10'($random(seed));
    wr(OFS_CLKSEL, 8'h30);
    wr(OFS_STAT, 8'h02);
    wr(OFS_CTRL, 8'h83);
    sleepReq <= 1'b1;
    n = 0;
    while (wakeReq !== 1'b1 && n < 400) begin
      waitCyc(1);
      n++;
    end
    chkBit(wakeReq, 1'b1);
    waitCyc(1);
    chkBit(wakeReq, 1'b0);
    // RC ticks run free, so the first TAD may be short by up to one tick period
    chkBit(n >= 10 * 8 + INSTR_CYC + 1 && n <= 11 * 8 + INSTR_CYC, 1'b1);
    @(posedge clk) sleepReq <= 1'b0;
    rdc(OFS_STAT, 8'h03);
    lastRes = fmt(target, 1'b1);
    rdc(OFS_RESHI, lastRes[15:8]);
    rdc(OFS_RESLO, lastRes[7:0]);
    // Without the enable the converter powers itself down instead
    wr(OFS_STAT, 8'h00);
    wr(OFS_CTRL, 8'h03);
    sleepReq <= 1'b1;
    n = 0;
    while (anaOut.powerOn !== 1'b0 && n < 400) begin
      waitCyc(1);
      n++;
      chkBit(wakeReq, 1'b0);
    end
    chkBit(anaOut.powerOn, 1'b0);
    rdc(OFS_CTRL, 8'h01);
    rdc(OFS_STAT, 8'h01);
    @(posedge clk) sleepReq <= 1'b0;
    $display("test halt with rc clock done");
    // Clearing the enable mid-run, then a reset mid-run
    wr(OFS_CLKSEL, 8'h60);
    wr(OFS_STAT, 8'h00);
    wr(OFS_CTRL, 8'h03);
    waitCyc(50);
    wr(OFS_CTRL, 8'h00);
    rdc(OFS_CTRL, 8'h00);
    rdc(OFS_STAT, 8'h00);
    chkBit(anaOut.powerOn, 1'b0);
    wr(OFS_CTRL, 8'hc1);
    wr(OFS_CTRL, 8'hc3);
    repeat (100) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(OFS_CTRL, 8'h00);
    rdc(OFS_STAT, 8'h00);
    rdc(OFS_RESHI, 8'h00);
    chkBit(anaOut.powerOn, 1'b0);
    chkBit(anaOut.refExt, 1'b0);
    $display("test disable and reset done");
    stop_test();
  end
endmodule
